// ==== include/aser_map.vh ====
// Purpose: Register map, field positions and counts of the serial port
// Assumes: Included by bare name from every design file of the port
// Notes:   Definitions only; word index times four is the byte address
`ifndef ASER_MAP_VH
`define ASER_MAP_VH

// Word indices of the registers on the bus
`define ASER_IDX_MODE   3'h0
`define ASER_IDX_STAT   3'h1
`define ASER_IDX_TXD    3'h2
`define ASER_IDX_RXD    3'h3
`define ASER_IDX_BRG    3'h4

// Mode register fields
`define ASER_M_EN       15
`define ASER_M_SIDL     13
`define ASER_M_IR_EN    12
`define ASER_M_RTS_SMPX 11
`define ASER_M_PINS_HI  9
`define ASER_M_PINS_LO  8
`define ASER_M_LPBK     6
`define ASER_M_RX_INV   4
`define ASER_M_FAST     3
`define ASER_M_PDS_HI   2
`define ASER_M_PDS_LO   1
`define ASER_M_TWO_STOP 0
`define ASER_MODE_WMASK 16'hBBFF
`define ASER_MODE_RST   16'h0000

// Status and control register fields
`define ASER_S_TXIS1    15
`define ASER_S_TXIS0    13
`define ASER_S_TXBRK    11
`define ASER_S_TXEN     10
`define ASER_S_TX_FULL  9
`define ASER_S_TX_IDLE  8
`define ASER_S_RXIS_HI  7
`define ASER_S_RXIS_LO  6
`define ASER_S_ADR_DET  5
`define ASER_S_RX_IDLE  4
`define ASER_S_PAR_ERR  3
`define ASER_S_FRM_ERR  2
`define ASER_S_OVR_ERR  1
`define ASER_S_RX_DATA  0

// Divisor reset value
`define ASER_BRG_RST    16'h0000

// Timing counts, in core clocks or in generator ticks
`define ASER_TXEN_IRQ_DLY 2'h2
`define ASER_STD_LAST   4'hF
`define ASER_STD_MID    4'h7
`define ASER_HS_LAST    4'h3
`define ASER_HS_MID     4'h1
`define ASER_BRK_LAST   4'hC
`define ASER_IR_PULSE   4'h3
`define ASER_IR_HOLD    5'h10
`define ASER_FIFO_DEPTH 4

`endif

// ==== rtl/aser_fifo.v ====
// Purpose: Four-entry flip-flop FIFO for the serial port data paths
// Assumes: Push when full and pop when empty are ignored
// Notes:   Head entry is always visible on rdata
`timescale 1ns/1ps
`default_nettype none
`include "aser_map.vh"

module aser_fifo #(
  parameter WIDTH = 9
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire             ce,
  input  wire             clr,
  input  wire             push,
  input  wire [WIDTH-1:0] wdata,
  input  wire             pop,
  output wire [WIDTH-1:0] rdata,
  output wire [2:0]       count,
  output wire             full,
  output wire             empty
);

  reg [WIDTH-1:0] mem_q [0:`ASER_FIFO_DEPTH-1]; // Storage entries
  reg [1:0]       wr_q;                         // Write index
  reg [1:0]       rd_q;                         // Read index
  reg [2:0]       cnt_q;                        // Entries held

  wire do_push = push & ~full;  // Full drops the word
  wire do_pop  = pop & ~empty;  // Empty pop is harmless

  assign rdata = mem_q[rd_q];
  assign count = cnt_q;
  assign full  = (cnt_q == `ASER_FIFO_DEPTH);
  assign empty = (cnt_q == 3'h0);

  // Pointers and level; clear wins over traffic
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wr_q  <= 2'h0;
      rd_q  <= 2'h0;
      cnt_q <= 3'h0;
    end else if (ce) begin
      if (clr) begin
        wr_q  <= 2'h0;
        rd_q  <= 2'h0;
        cnt_q <= 3'h0;
      end else begin
        if (do_push) wr_q <= wr_q + 2'h1;
        if (do_pop) rd_q <= rd_q + 2'h1;
        if (do_push & ~do_pop) cnt_q <= cnt_q + 3'h1;
        else if (do_pop & ~do_push) cnt_q <= cnt_q - 3'h1;
      end
    end
  end

  // Data entries need no reset; level guards their use
  always @(posedge core_clk) begin
    if (ce & do_push & ~clr) mem_q[wr_q] <= wdata;
  end

endmodule // aser_fifo

`default_nettype wire

// ==== rtl/aser_brg.v ====
// Purpose: Baud rate generator, one tick per divisor plus one clocks
// Assumes: Divisor stable between writes; clr restarts the period
// Notes:   clk16 is high for the first half of each tick period
`timescale 1ns/1ps
`default_nettype none
`include "aser_map.vh"

module aser_brg (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        clr,
  input  wire [15:0] divisor,
  output reg         tick,
  output reg         clk16
);

  reg  [15:0] cnt_q;                       // Period timer
  wire [15:0] half = {1'b0, divisor[15:1]}; // Half period point

  // Free-running timer; clear makes the new rate apply at once
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
      clk16 <= 1'b0;
    end else if (ce) begin
      if (clr) begin
        cnt_q <= 16'h0000;
        tick  <= 1'b0;
        clk16 <= 1'b0;
      end else if (cnt_q == divisor) begin
        cnt_q <= 16'h0000;
        tick  <= 1'b1;
        clk16 <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        tick  <= 1'b0;
        clk16 <= (cnt_q < half);
      end
    end
  end

endmodule // aser_brg

`default_nettype wire

// ==== rtl/aser_port.v ====
// Purpose: Asynchronous serial port with FIFOs, break, flow control, IR
// Assumes: Avalon-MM slave, byte address, one aligned word per register
// Notes:   Interrupt outputs are one-cycle pulses for an outside controller
`timescale 1ns/1ps
`default_nettype none
`include "aser_map.vh"

// Notes on behaviour
// - Standard rate: clock / (16*(divisor+1))
// - Transmit enable raises tx interrupt after two
// - Low byte write loads shifter, next clock
// - Enable after load restarts cleared baud clock
// - Tx interrupt follows tx mode select
// - Nine-bit mode takes writes with both low byte lanes only
// - Break: dummy character starts break, value ignored
// - Hardware clears break bit, then sends next
// - Rx interrupt follows rx mode select
// - Overrun flag sticks until software clears it
// - Reading rx data advances FIFO and flags
// - Handshake pins follow pin enable field
// - Infrared works only with high-speed clear
// - Pin field 11 drives 16x clock out
// - Infrared enable routes pins through codec
// - Parity select: none, even, odd, nine-bit
// - High speed: four ticks per bit
// - Divisor write clears baud timer at once
// - Stop select gives one or two stops
module aser_port (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        rx_pin,
  input  wire        clear_to_send_pin_n,
  output reg         tx_pin,
  output wire        tx_pin_oe,
  output reg         request_to_send_pin_n,
  output wire        request_to_send_pin_oe,
  output reg         tx_irq,
  output reg         rx_irq
);

  // Engine states
  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA  = 3'h2;
  localparam ST_PAR   = 3'h3;
  localparam ST_STOP  = 3'h4;
  localparam ST_BRK   = 3'h5;

  // Byte-enable merge of a 16-bit register
  function [15:0] merge16;
    input [15:0] old_v;
    input [15:0] new_v;
    input [1:0]  be;
    begin
      merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
                 be[0] ? new_v[7:0]  : old_v[7:0]};
    end
  endfunction

  // Last tick of a bit; four or sixteen per bit
  function [3:0] bit_last;
    input hs;
    begin
      bit_last = hs ? `ASER_HS_LAST : `ASER_STD_LAST;
    end
  endfunction

  // Control and status registers
  reg [15:0] mode_q;      // Serial mode control
  reg [15:0] brg_q;       // Baud divisor
  reg [1:0]  txis_q;      // Tx interrupt mode select
  reg [1:0]  rxis_q;      // Rx interrupt mode select
  reg        adden_q;     // Stored only, no address detect
  reg        txbrk_q;     // Send break bit
  reg        txen_q;      // Tx enable bit
  reg        ovr_q;       // Rx overrun flag
  reg        ack_q;       // Bus answer phase
  reg [1:0]  txen_cnt_q;  // Delay to enable interrupt

  // Transmit engine
  reg [2:0]  tx_st_q;     // Tx state
  reg [8:0]  tx_sh_q;     // Tx shift register
  reg [3:0]  tx_sub_q;    // Tick within bit
  reg [3:0]  tx_cnt_q;    // Bit counter
  reg        tx_par_q;    // Parity bit to send

  // Receive engine
  reg [2:0]  rx_st_q;     // Rx state
  reg [8:0]  rx_sh_q;     // Rx shift register
  reg [3:0]  rx_sub_q;    // Tick within bit
  reg [3:0]  rx_cnt_q;    // Bit counter
  reg        rx_pb_q;     // Received parity bit
  reg        rx_prev_q;   // Line one cycle ago
  reg [4:0]  ir_hold_q;   // IR decoder stretch

  // Mode fields
  wire       port_en = mode_q[`ASER_M_EN];
  wire [1:0] pin_sel = mode_q[`ASER_M_PINS_HI:`ASER_M_PINS_LO];
  wire       hs      = mode_q[`ASER_M_FAST];
  wire [1:0] pds     = mode_q[`ASER_M_PDS_HI:`ASER_M_PDS_LO];
  wire       nine    = (pds == 2'h3);
  wire       par_en  = (pds == 2'h1) | (pds == 2'h2);
  wire       odd     = (pds == 2'h2);
  wire       lpbk    = mode_q[`ASER_M_LPBK];
  wire       ir_on   = mode_q[`ASER_M_IR_EN] & ~hs;
  wire [3:0] last    = bit_last(hs);
  wire [3:0] mid     = hs ? `ASER_HS_MID : `ASER_STD_MID;
  wire [3:0] nlast   = nine ? 4'h8 : 4'h7;

  // Bus decode; answer on the second edge of a request
  wire       req     = avs_read | avs_write;
  wire       acc     = req & ack_q;
  wire       wr      = acc & avs_write;
  wire       rd      = acc & avs_read;
  wire [2:0] idx     = avs_address[4:2];
  wire       s_mode  = (idx == `ASER_IDX_MODE);
  wire       s_stat  = (idx == `ASER_IDX_STAT);
  wire       s_txd   = (idx == `ASER_IDX_TXD);
  wire       s_rxd   = (idx == `ASER_IDX_RXD);
  wire       s_brg   = (idx == `ASER_IDX_BRG);
  wire [15:0] wd     = avs_writedata[15:0];
  assign avs_waitrequest = req & ~ack_q;

  // Baud generator; divisor write, disable or enable restart it
  wire txen_set = wr & s_stat & avs_byteenable[1] &
                  wd[`ASER_S_TXEN] & ~txen_q;
  wire brg_clr  = ~port_en | (wr & s_brg) | txen_set;
  wire tick;
  wire clk16;

  aser_brg u_brg (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .clr      (brg_clr),
    .divisor  (brg_q),
    .tick     (tick),
    .clk16    (clk16)
  );

  // Transmit FIFO; nine-bit mode needs both low lanes
  wire       txf_push = wr & s_txd & port_en &
                        (nine ? (avs_byteenable[1:0] == 2'h3)
                              : avs_byteenable[0]);
  wire [8:0] txf_wd   = nine ? wd[8:0] : {1'b0, wd[7:0]};
  wire [8:0] txf_rd;
  wire [2:0] txf_cnt;
  wire       txf_full;
  wire       txf_empty;
  wire       cts_ok   = (pin_sel != 2'h2) | ~clear_to_send_pin_n;
  wire       tx_load  = (tx_st_q == ST_IDLE) & ~txf_empty & txen_q &
                        port_en & cts_ok;

  aser_fifo #(.WIDTH(9)) u_txf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .clr      (~port_en),
    .push     (txf_push),
    .wdata    (txf_wd),
    .pop      (tx_load),
    .rdata    (txf_rd),
    .count    (txf_cnt),
    .full     (txf_full),
    .empty    (txf_empty)
  );

  // Receive FIFO holds parity error, framing error and data
  reg         rx_push;
  reg  [10:0] rx_ent;
  wire [10:0] rxf_rd;
  wire [2:0]  rxf_cnt;
  wire        rxf_full;
  wire        rxf_empty;
  wire        rx_ovr  = rx_push & rxf_full;
  wire        rxf_pop = rd & s_rxd;

  aser_fifo #(.WIDTH(11)) u_rxf (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .clr      (~port_en),
    .push     (rx_push),
    .wdata    (rx_ent),
    .pop      (rxf_pop),
    .rdata    (rxf_rd),
    .count    (rxf_cnt),
    .full     (rxf_full),
    .empty    (rxf_empty)
  );

  // Transmit line level for the current state
  reg tx_line;
  always @* begin
    case (tx_st_q)
      ST_START: tx_line = 1'b0;
      ST_BRK:   tx_line = 1'b0;
      ST_DATA:  tx_line = tx_sh_q[0];
      ST_PAR:   tx_line = tx_par_q;
      default:  tx_line = 1'b1;
    endcase
  end

  // IR encoder: short high pulse for each low bit, idle low
  wire ir_tx = ~tx_line & (tx_sub_q < `ASER_IR_PULSE);

  // Receive line: loopback, inversion and IR decoder
  wire rx_raw = rx_pin ^ mode_q[`ASER_M_RX_INV];
  wire rx_bit = lpbk  ? tx_line :
                ir_on ? ((ir_hold_q == 5'h00) & ~rx_raw) :
                rx_raw;
  wire tx_done = tick & (tx_sub_q == last) & (tx_st_q == ST_STOP) &
                 (tx_cnt_q == {3'h0, mode_q[`ASER_M_TWO_STOP]});
  wire brk_end = tick & (tx_sub_q == last) & (tx_st_q == ST_BRK) &
                 (tx_cnt_q == `ASER_BRK_LAST);

  // Register writes and hardware-set flags; set wins over clear
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mode_q     <= `ASER_MODE_RST;
      brg_q      <= `ASER_BRG_RST;
      txis_q     <= 2'h0;
      rxis_q     <= 2'h0;
      adden_q    <= 1'b0;
      txbrk_q    <= 1'b0;
      txen_q     <= 1'b0;
      ovr_q      <= 1'b0;
      txen_cnt_q <= 2'h0;
    end else if (ce) begin
      if (wr & s_mode)
        mode_q <= merge16(mode_q, wd, avs_byteenable[1:0]) &
                  `ASER_MODE_WMASK;
      if (wr & s_brg)
        brg_q <= merge16(brg_q, wd, avs_byteenable[1:0]);
      // Break bit: software write wins over hardware clear
      if (wr & s_stat & avs_byteenable[1]) begin
        txis_q  <= {wd[`ASER_S_TXIS1], wd[`ASER_S_TXIS0]};
        txbrk_q <= wd[`ASER_S_TXBRK];
        txen_q  <= wd[`ASER_S_TXEN];
      end else if (brk_end) begin
        txbrk_q <= 1'b0;
      end
      if (wr & s_stat & avs_byteenable[0]) begin
        rxis_q  <= wd[`ASER_S_RXIS_HI:`ASER_S_RXIS_LO];
        adden_q <= wd[`ASER_S_ADR_DET];
      end
      // Overrun sticks; only a written zero clears it
      ovr_q <= rx_ovr | (ovr_q & ~(wr & s_stat & avs_byteenable[0] &
                                   ~wd[`ASER_S_OVR_ERR]));
      // Count down from the enable edge to the interrupt
      if (txen_set)
        txen_cnt_q <= `ASER_TXEN_IRQ_DLY;
      else if (txen_cnt_q != 2'h0)
        txen_cnt_q <= txen_cnt_q - 2'h1;
    end
  end

  // Bus answer phase and registered read data
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else if (ce) begin
      ack_q <= req & ~ack_q;
      if (avs_read & ~ack_q) begin
        avs_readdata <= 32'h0000_0000;      // Unmapped reads zero
        if (s_mode) avs_readdata[15:0] <= mode_q;
        if (s_brg)  avs_readdata[15:0] <= brg_q;
        if (s_rxd)  avs_readdata[8:0]  <= rxf_rd[8:0];
        if (s_stat) begin
          avs_readdata[`ASER_S_TXIS1]   <= txis_q[1];
          avs_readdata[`ASER_S_TXIS0]   <= txis_q[0];
          avs_readdata[`ASER_S_TXBRK]   <= txbrk_q;
          avs_readdata[`ASER_S_TXEN]    <= txen_q;
          avs_readdata[`ASER_S_TX_FULL] <= txf_full;
          avs_readdata[`ASER_S_TX_IDLE] <= txf_empty &
                                           (tx_st_q == ST_IDLE);
          avs_readdata[`ASER_S_RXIS_HI] <= rxis_q[1];
          avs_readdata[`ASER_S_RXIS_LO] <= rxis_q[0];
          avs_readdata[`ASER_S_ADR_DET] <= adden_q;
          avs_readdata[`ASER_S_RX_IDLE] <= (rx_st_q == ST_IDLE);
          avs_readdata[`ASER_S_PAR_ERR] <= ~rxf_empty & rxf_rd[10];
          avs_readdata[`ASER_S_FRM_ERR] <= ~rxf_empty & rxf_rd[9];
          avs_readdata[`ASER_S_OVR_ERR] <= ovr_q;
          avs_readdata[`ASER_S_RX_DATA] <= ~rxf_empty;
        end
      end
    end
  end

  // Transmit engine: one bit per last tick of its period
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tx_st_q  <= ST_IDLE;
      tx_sh_q  <= 9'h000;
      tx_sub_q <= 4'h0;
      tx_cnt_q <= 4'h0;
      tx_par_q <= 1'b0;
    end else if (ce) begin
      if (~port_en) begin
        tx_st_q <= ST_IDLE;
      end else if (tx_load) begin
        // Dummy value is dropped when a break is armed
        tx_st_q  <= txbrk_q ? ST_BRK : ST_START;
        tx_sh_q  <= txf_rd;
        tx_par_q <= ^txf_rd[7:0] ^ odd;
        tx_sub_q <= 4'h0;
        tx_cnt_q <= 4'h0;
      end else if (tick & (tx_st_q != ST_IDLE)) begin
        if (tx_sub_q != last) begin
          tx_sub_q <= tx_sub_q + 4'h1;
        end else begin
          tx_sub_q <= 4'h0;
          tx_cnt_q <= 4'h0;
          case (tx_st_q)
            ST_START: tx_st_q <= ST_DATA;
            ST_DATA: begin
              tx_sh_q <= {1'b0, tx_sh_q[8:1]};
              if (tx_cnt_q == nlast)
                tx_st_q <= par_en ? ST_PAR : ST_STOP;
              else
                tx_cnt_q <= tx_cnt_q + 4'h1;
            end
            ST_PAR: tx_st_q <= ST_STOP;
            ST_STOP: begin
              if (tx_done)
                tx_st_q <= ST_IDLE;
              else
                tx_cnt_q <= tx_cnt_q + 4'h1;
            end
            ST_BRK: begin
              if (brk_end)
                tx_st_q <= ST_STOP;
              else
                tx_cnt_q <= tx_cnt_q + 4'h1;
            end
            default: tx_st_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  // Receive engine: start edge, then mid-bit sampling
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_st_q   <= ST_IDLE;
      rx_sh_q   <= 9'h000;
      rx_sub_q  <= 4'h0;
      rx_cnt_q  <= 4'h0;
      rx_pb_q   <= 1'b0;
      rx_prev_q <= 1'b1;
      ir_hold_q <= 5'h00;
      rx_push   <= 1'b0;
      rx_ent    <= 11'h000;
    end else if (ce) begin
      rx_prev_q <= rx_bit;
      rx_push   <= 1'b0;
      // IR pulse stretched to a full low bit
      if (~port_en | ~ir_on)
        ir_hold_q <= 5'h00;
      else if (rx_raw)
        ir_hold_q <= `ASER_IR_HOLD;
      else if (tick & (ir_hold_q != 5'h00))
        ir_hold_q <= ir_hold_q - 5'h01;
      if (~port_en) begin
        rx_st_q <= ST_IDLE;
      end else if (rx_st_q == ST_IDLE) begin
        if (rx_prev_q & ~rx_bit) begin
          rx_st_q  <= ST_START;
          rx_sub_q <= 4'h0;
          rx_cnt_q <= 4'h0;
        end
      end else if (tick) begin
        rx_sub_q <= (rx_sub_q == last) ? 4'h0 : rx_sub_q + 4'h1;
        case (rx_st_q)
          ST_START: begin
            if ((rx_sub_q == mid) & rx_bit)
              rx_st_q <= ST_IDLE;           // Glitch, not a start
            else if (rx_sub_q == last)
              rx_st_q <= ST_DATA;
          end
          ST_DATA: begin
            if (rx_sub_q == mid)
              rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
            if (rx_sub_q == last) begin
              if (rx_cnt_q == nlast) begin
                rx_st_q  <= par_en ? ST_PAR : ST_STOP;
                rx_cnt_q <= 4'h0;
              end else begin
                rx_cnt_q <= rx_cnt_q + 4'h1;
              end
            end
          end
          ST_PAR: begin
            if (rx_sub_q == mid)
              rx_pb_q <= rx_bit;
            if (rx_sub_q == last)
              rx_st_q <= ST_STOP;
          end
          ST_STOP: begin
            // Finish at mid stop so the next start is not missed
            if (rx_sub_q == mid) begin
              rx_st_q <= ST_IDLE;
              rx_push <= 1'b1;
              rx_ent[8:0] <= nine ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
              rx_ent[9]   <= ~rx_bit;
              rx_ent[10]  <= par_en &
                             (rx_pb_q ^ ^rx_sh_q[8:1] ^ odd);
            end
          end
          default: rx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Pins and interrupt pulses, all registered
  always @(posedge core_clk) begin
    if (!rst_n) begin
      tx_pin                <= 1'b1;
      request_to_send_pin_n <= 1'b1;
      tx_irq                <= 1'b0;
      rx_irq                <= 1'b0;
    end else if (ce) begin
      // Loopback keeps the pin idle so the far end sees nothing
      tx_pin <= ~port_en ? 1'b1 :
                lpbk     ? 1'b1 :
                ir_on    ? ir_tx : tx_line;
      case (pin_sel)
        2'h3:    request_to_send_pin_n <= clk16;
        default: request_to_send_pin_n <=
                   mode_q[`ASER_M_RTS_SMPX] ? (tx_st_q == ST_IDLE)
                                         : rxf_full;
      endcase
      // Tx modes: 00 per load, 01 all sent, 10 FIFO drained
      case (txis_q)
        2'h0:    tx_irq <= (txen_cnt_q == 2'h1) | tx_load;
        2'h1:    tx_irq <= (txen_cnt_q == 2'h1) | (tx_done & txf_empty);
        2'h2:    tx_irq <= (txen_cnt_q == 2'h1) |
                           (tx_load & (txf_cnt == 3'h1));
        default: tx_irq <= (txen_cnt_q == 2'h1); // Reserved mode
      endcase
      // Rx modes: 0x each char, 10 three held, 11 four held
      case (rxis_q)
        2'h2:    rx_irq <= rx_push & ~rxf_full & (rxf_cnt == 3'h2);
        2'h3:    rx_irq <= rx_push & ~rxf_full & (rxf_cnt == 3'h3);
        default: rx_irq <= rx_push & ~rxf_full;
      endcase
    end
  end

  // Pins released while the port is off
  assign tx_pin_oe              = port_en;
  assign request_to_send_pin_oe = port_en & (pin_sel != 2'h0);

endmodule // aser_port

`default_nettype wire

// ==== dv/aser_checker.sv ====
// Purpose: Port-level checks of the serial port
// Assumes: ce held high, infrared modes unused
// Notes:   Bound to every aser_port instance
`timescale 1ns/1ps
`default_nettype none
module aser_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tx_pin,
  input wire logic        tx_pin_oe,
  input wire logic        tx_irq,
  input wire logic        rx_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic wr_st;  // Accepted write to status lane 1
  logic txen_q; // Software copy of tx enable
  assign wr_st = avs_write && !avs_waitrequest
    && avs_address[4:2] == 3'h1 && avs_byteenable[1];
  // Only a 0 to 1 enable write may raise the early interrupt
  always @(posedge core_clk)
    if (!rst_n) txen_q <= 1'b0;
    else if (wr_st) txen_q <= avs_writedata[10];
  bus_wait_a: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bus answer late");
  unmap_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[4:2] > 3'h4 |-> avs_readdata == 32'h0) else $error("unmapped read nonzero");
  txen_irq_a: assert property (wr_st && avs_writedata[10] && !txen_q |-> ##[2:3] tx_irq) else $error("no tx irq on enable");
  tx_pulse_a: assert property (tx_irq |=> !tx_irq) else $error("tx irq too long");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq) else $error("rx irq too long");
  off_idle_a: assert property (!tx_pin_oe [*2] |-> tx_pin) else $error("line low while off");
  start_len_a: assert property ($fell(tx_pin) |-> !tx_pin [*4]) else $error("bit too short");
  on_idle_a: assert property ($rose(tx_pin_oe) |-> tx_pin [*3]) else $error("line not idle");
endmodule // aser_checker
bind aser_port aser_checker i_chk (.*);
`default_nettype wire

// ==== dv/aser_peer.sv ====
// Purpose: Remote serial peer driving the receive line
// Assumes: Sixteen clocks per bit
// Notes:   bad_stop sends a low stop bit on purpose
`timescale 1ns/1ps
`default_nettype none
module aser_peer (
  input  wire logic       core_clk,
  input  wire logic [7:0] data,
  input  wire logic       go,
  input  wire logic       bad_stop,
  output var  logic       rx_pin,
  output var  logic       busy
);
  logic [9:0] sh; // Frame, start bit first
  int         n;  // Clock count in frame
  initial rx_pin = 1'b1;
  initial busy = 1'b0;
  // One frame per go; line idles high between frames
  always @(posedge core_clk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      sh = {~bad_stop, data, 1'b0};
      for (n = 0; n < 160; n++) begin
        rx_pin <= sh[n / 16];
        @(posedge core_clk);
      end
      rx_pin <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule // aser_peer
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench of the serial port
// Assumes: Divisor 0, so one bit lasts 16 clocks
// Notes:   Peer model drives the receive line
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 0, rst_n = 0, rq_r = 0, rq_w = 0, rx, tx, txoe, rtsn, rtsoe;
  logic txi, rxi, wq, pgo = 0, pbad = 0, pbusy;
  logic [4:0] ad = 0; logic [3:0] be = 0; logic [31:0] wd = 0, rdt, q;
  logic [7:0] pd = 0; logic [11:0] v; logic [8:0] d = 9'h1A5;
  int n_mismatch = 0, tests_run = 0, cyc = 0, i, k, n_txi = 0, n_rxi = 0;
  aser_port i_aser_port (.core_clk(clk), .rst_n(rst_n), .ce(1'b1),
    .avs_address(ad), .avs_read(rq_r), .avs_write(rq_w),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdt),
    .avs_waitrequest(wq), .rx_pin(rx), .clear_to_send_pin_n(1'b0),
    .tx_pin(tx), .tx_pin_oe(txoe), .request_to_send_pin_n(rtsn),
    .request_to_send_pin_oe(rtsoe), .tx_irq(txi), .rx_irq(rxi));
  aser_peer i_aser_peer (.core_clk(clk), .data(pd), .go(pgo),
    .bad_stop(pbad), .rx_pin(rx), .busy(pbusy));
  task automatic chk(input string nm, input logic [15:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  // One access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [2:0] a,
      input logic [15:0] x, input logic [3:0] b);
    @(posedge clk);
    rq_w <= w; rq_r <= !w; ad <= {a, 2'b00}; wd <= {16'h0000, x}; be <= b;
    do @(posedge clk); while (wq !== 1'b0);
    q = rdt;
    rq_w <= 1'b0; rq_r <= 1'b0;
  endtask
  // Samples each bit mid-way; v holds the start bit first
  task automatic txchk(input int n);
    wait (tx === 1'b0);
    repeat (8) @(posedge clk);
    for (k = 0; k < n; k++) begin
      chk("tx bit", tx, v[k]);
      repeat (16) @(posedge clk);
    end
  endtask
  task automatic psend(input logic [7:0] x, input logic bad);
    pd <= x; pbad <= bad; pgo <= 1'b1;
    repeat (2) @(posedge clk);
    pgo <= 1'b0;
    wait (pbusy === 1'b0);
    repeat (32) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #25 clk = ~clk;
  // Hang guard and interrupt pulse counts
  always @(posedge clk) begin
    cyc++;
    if (txi === 1'b1) n_txi++;
    if (rxi === 1'b1) n_rxi++;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 3'h0, 16'h0000, 4'h3);
    chk("mode", q[15:0], 16'h0000);
    bus(0, 3'h5, 16'h0000, 4'h3);
    chk("unmapped", q[15:0], 16'h0000);
    bus(1, 3'h4, 16'h0000, 4'h3);
    bus(1, 3'h0, 16'h8000, 4'h3);
    bus(1, 3'h1, 16'h0400, 4'h2);
    for (i = 0; i < 4; i++) begin
      bus(1, 3'h0, 16'h8000 | 16'(i << 1), 4'h3);
      v = {1'b1, i == 0 ? 1'b1 : i == 1 ? ^d[7:0] : i == 2 ? ~^d[7:0] : d[8],
        d[7:0], 1'b0};
      bus(1, 3'h2, {7'h00, d}, 4'h3);
      txchk(i ? 11 : 10);
    end
    bus(1, 3'h0, 16'h8000, 4'h3);
    bus(1, 3'h1, 16'h0C00, 4'h2);
    bus(1, 3'h2, 16'h00FF, 4'h3);
    bus(1, 3'h2, 16'h0055, 4'h3);
    wait (tx === 1'b0);
    k = 0;
    do begin @(posedge clk); k++; end while (tx !== 1'b1);
    chk("break len", 16'((k + 8) / 16), 16'h000D);
    v = {3'b111, 8'h55, 1'b0};
    txchk(10);
    bus(0, 3'h1, 16'h0000, 4'h3);
    chk("break bit", q[11], 1'b0);
    chk("tx irqs", 16'(n_txi), 16'h0007);
    for (i = 0; i < 5; i++) psend(8'(8'h10 + i), i == 1);
    bus(0, 3'h1, 16'h0000, 4'h3);
    chk("overrun", q[1], 1'b1);
    chk("rx irqs", 16'(n_rxi), 16'h0004);
    chk("rts full", rtsn, 1'b1);
    chk("rts oe", rtsoe, 1'b0);
    for (i = 0; i < 4; i++) begin
      bus(0, 3'h1, 16'h0000, 4'h3);
      chk("frame err", q[2], i == 1);
      bus(0, 3'h3, 16'h0000, 4'h3);
      chk("rx data", q[7:0], 8'(8'h10 + i));
    end
    bus(1, 3'h1, 16'h0000, 4'h1);
    bus(0, 3'h1, 16'h0000, 4'h3);
    chk("overrun clr", q[1], 1'b0);
    chk("rts free", rtsn, 1'b0);
    final_report();
  end
endmodule // testbench
`default_nettype wire
